/* verilog/jstpg_pkg.sv */
// Shared constants for the serial test pattern generator pair
package jstpg_pkg;
  // Test pattern selection codes
  localparam logic [3:0] PAT_OFF    = 4'h0; // Normal data path
  localparam logic [3:0] PAT_PRBS7  = 4'h1;
  localparam logic [3:0] PAT_PRBS9  = 4'h2;
  localparam logic [3:0] PAT_PRBS15 = 4'h3;
  localparam logic [3:0] PAT_PRBS23 = 4'h4;
  localparam logic [3:0] PAT_PRBS31 = 4'h5;
  localparam logic [3:0] PAT_CLOCK  = 4'h6;
  localparam logic [3:0] PAT_RAMP   = 4'h7;
  localparam logic [3:0] PAT_SHORT  = 4'h8;
  localparam logic [3:0] PAT_D215   = 4'h9;
  localparam logic [3:0] PAT_K285   = 4'ha;
  localparam logic [3:0] PAT_REPILA = 4'hb;
  localparam logic [3:0] PAT_RPAT   = 4'hc;
  // Link format field layout
  localparam int FMT_LANES_LSB = 0;   // 2 bits: 0=1,1=2,2/3=4 lanes per group
  localparam int FMT_ENC64_BIT = 2;   // 1 = 64b/66b, 0 = 8b/10b
  localparam int FMT_DUAL_BIT  = 3;   // 1 = dual channel
  // Sync header stream codes
  localparam logic [1:0] SH_NONE  = 2'h0;
  localparam logic [1:0] SH_CRC12 = 2'h1;
  localparam logic [1:0] SH_FEC   = 2'h2;
  // Characters
  localparam logic [7:0] OCT_D215 = 8'hb5;
  localparam logic [7:0] OCT_K285 = 8'hbc;
  localparam logic [7:0] OCT_K280 = 8'h1c; // Multiframe start
  localparam logic [7:0] OCT_K283 = 8'h7c; // Multiframe end
  localparam logic [7:0] OCT_ONES = 8'hff;
  localparam logic [7:0] OCT_ZERO = 8'h00;
  localparam logic [7:0] RPAT_LAST = 8'h0b; // Last of twelve octets
  // Alignment run timing: 4 multiframes of 32 octets
  localparam logic [6:0] ILA_LAST = 7'h7f;
  localparam logic [4:0] MF_LAST  = 5'h1f;
  // Host register map and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PAT    = 8'h04;
  localparam logic [7:0] REG_FMT    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_LANE0  = 8'h10;
  localparam logic [7:0] CTRL_RESET = 8'h20; // Converter-off bit set out of reset
  localparam logic [3:0] FMT_RESET  = 4'h2;  // 8b/10b, single channel, 4 lanes
  localparam int ST_REFUSED = 0;
  localparam int ST_TRUSTED = 1;
  localparam int ST_ILA     = 2;
  // Host sync request hold and pipeline flush times
  localparam int SYNC_REQ_NS = 200;
  localparam int CLK_NS      = 10;
  localparam int SYNC_REQ_CYC = (SYNC_REQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLUSH_CYC    = 64;
endpackage

/* verilog/jstpg_if.sv */
// Link between the serial transmitter end and its receiver/controller end
`timescale 1ns/100ps
interface jstpg_if #(parameter int NL = 8);
  logic            powerdown_input;     // Power-down pin
  logic            full_powerdown;      // Configuration full power-down
  logic            chan_b_powerdown;    // Second channel off in dual mode
  logic            link_enable;         // Serial link enable
  logic            fec_select;          // Sync header stream: 1 FEC, 0 CRC-12
  logic [3:0]      test_pattern_select; // Pattern code
  logic [3:0]      link_format_select;  // Lane count, encoding, channel mode
  logic            sync_request_n;      // Receiver sync request, low active
  logic [NL*8-1:0] lane_data;           // One octet per lane per clock
  logic [NL-1:0]   lane_k;              // Octet is a control character
  logic [NL-1:0]   lane_raw;            // Octet bypasses coding and scrambling
  logic [NL-1:0]   lane_drv_en;         // Lane output driver on
  logic [1:0]      sync_hdr_code;       // Active sync header stream mode
  modport dev  (input powerdown_input, full_powerdown, chan_b_powerdown, link_enable,
                fec_select, test_pattern_select, link_format_select, sync_request_n,
                output lane_data, lane_k, lane_raw, lane_drv_en, sync_hdr_code);
  modport host (output powerdown_input, full_powerdown, chan_b_powerdown, link_enable,
                fec_select, test_pattern_select, link_format_select, sync_request_n,
                input lane_data, lane_k, lane_raw, lane_drv_en, sync_hdr_code);
endinterface // jstpg_if

/* verilog/jstpg_device_end.sv */
// Serial transmitter end: lane drivers, link states and test pattern insertion
// Functional notes
// - Error checking uses only twelve-bit CRC
// - FEC offered as the other header mode
// - Power-down pin high disables lane drivers
// - Config full power-down; single channel power-down
// - Controller relinks and waits flush after power-down
// - Controller sets converter-off calibration bit
// - Lane count fixed by format, any pattern
// - Pattern changed only while link disabled
// - PRBS bypasses coding and scrambling
// - PRBS7 taps six and seven
// - PRBS9/15/23/31 tap pairs as listed
// - Each lane starts PRBS at distinct phase
// - Clock pattern eight ones eight zeros
// - Ramp after alignment run or initialization
// - Ramp 00 to FF, all lanes, coded
// - Short transport pattern repeats every two frames
// - Lane k sends k then FF minus k
// - Endless D21.5 in both encodings
// - Endless K28.5, 8b/10b only
// - Sync request, then alignment run forever
// - Twelve-octet modified RPAT sequence
`timescale 1ns/100ps
module jstpg_device_end #(
  parameter int NL = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  jstpg_if.dev               lnk,
  input  wire logic [NL*8-1:0] fmt_data,
  output logic [3:0]         link_state_ff,
  output logic               drv_any_ff
);
  localparam int GS = NL / 2; // Lanes per channel group

  // Link layer states
  typedef enum logic [3:0] {
    JSTPG_OFF  = 4'b0001,
    JSTPG_CGS  = 4'b0010,
    JSTPG_ILA  = 4'b0100,
    JSTPG_DATA = 4'b1000
  } jstpg_state_t;

  jstpg_state_t state_ff;      // Current link state
  logic [6:0]   ila_cnt_ff;    // Octet position in alignment run
  logic [7:0]   ramp_ff;       // Ramp octet
  logic         frame_ff;      // Short transport frame number
  logic [7:0]   rpat_idx_ff;   // Modified RPAT position
  logic         clk_half_ff;   // Clock pattern half
  logic [NL-1:0] lane_on;      // Lane powered per format
  logic         powered;       // Device not powered down
  logic         enc64;         // 64b/66b coding chosen
  logic [3:0]   pat;           // Pattern select shorthand

  assign enc64    = lnk.link_format_select[jstpg_pkg::FMT_ENC64_BIT];
  assign pat      = lnk.test_pattern_select;
  assign powered  = !lnk.powerdown_input && !lnk.full_powerdown;

  // Lane power map: depends on format and power state only, never on pattern
  for (genvar g = 0; g < NL; g++) begin : g_on
    localparam int K = g % GS;
    logic cnt_ok;
    logic grp_ok;
    always_comb begin
      unique case (lnk.link_format_select[jstpg_pkg::FMT_LANES_LSB +: 2])
        2'h0:    cnt_ok = (K < 1);
        2'h1:    cnt_ok = (K < 2);
        default: cnt_ok = (K < 4);
      endcase
    end
    // Group B off when its channel alone is down
    assign grp_ok = (g < GS) || !(lnk.link_format_select[jstpg_pkg::FMT_DUAL_BIT] &&
                                  lnk.chan_b_powerdown);
    assign lane_on[g] = cnt_ok && grp_ok && powered;
  end

  // Driver enables registered straight to the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lnk.lane_drv_en <= '0;
      drv_any_ff      <= 1'b0;
    end else begin
      lnk.lane_drv_en <= lane_on;
      drv_any_ff      <= |lane_on;
    end
  end

  // Sync header mode: CRC-3 is never offered, so only CRC-12 or FEC
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lnk.sync_hdr_code <= jstpg_pkg::SH_NONE;
    end else if (!enc64) begin
      lnk.sync_hdr_code <= jstpg_pkg::SH_NONE;
    end else if (lnk.fec_select) begin
      lnk.sync_hdr_code <= jstpg_pkg::SH_FEC;
    end else begin
      lnk.sync_hdr_code <= jstpg_pkg::SH_CRC12;
    end
  end

  // Link state machine; a sync request restarts 8b/10b at any point
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= JSTPG_OFF;
      ila_cnt_ff <= '0;
    end else if (!lnk.link_enable || !powered) begin
      state_ff   <= JSTPG_OFF;
      ila_cnt_ff <= '0;
    end else if (!enc64 && !lnk.sync_request_n) begin
      state_ff   <= JSTPG_CGS;
      ila_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        JSTPG_OFF:  state_ff <= enc64 ? JSTPG_DATA : JSTPG_CGS;
        JSTPG_CGS:  state_ff <= enc64 ? JSTPG_DATA : JSTPG_ILA;
        JSTPG_ILA: begin
          ila_cnt_ff <= ila_cnt_ff + 7'h01;
          // Repeated mode wraps the run instead of entering data
          if (ila_cnt_ff == jstpg_pkg::ILA_LAST && pat != jstpg_pkg::PAT_REPILA) begin
            state_ff <= JSTPG_DATA;
          end
        end
        JSTPG_DATA: state_ff <= JSTPG_DATA;
      endcase
    end
  end

  // Pattern counters run only in the data phase so the ramp starts at 00
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_ff     <= '0;
      frame_ff    <= 1'b0;
      rpat_idx_ff <= '0;
    end else if (state_ff != JSTPG_DATA) begin
      ramp_ff     <= '0;
      frame_ff    <= 1'b0;
      rpat_idx_ff <= '0;
    end else begin
      ramp_ff     <= ramp_ff + 8'h01;
      frame_ff    <= !frame_ff;
      rpat_idx_ff <= (rpat_idx_ff == jstpg_pkg::RPAT_LAST) ? 8'h00 : rpat_idx_ff + 8'h01;
    end
  end

  // Clock pattern half select: one octet of ones, one of zeros
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_half_ff <= 1'b0;
    end else begin
      clk_half_ff <= !clk_half_ff;
    end
  end

  // Modified RPAT table
  function automatic logic [7:0] rpat_oct(logic [7:0] i);
    unique case (i)
      8'h00:   return 8'hbe;
      8'h01:   return 8'hd7;
      8'h02:   return 8'h23;
      8'h03:   return 8'h47;
      8'h04:   return 8'h6b;
      8'h05:   return 8'h8f;
      8'h06:   return 8'hb3;
      8'h07:   return 8'h14;
      8'h08:   return 8'h5e;
      8'h09:   return 8'hfb;
      8'h0a:   return 8'h35;
      default: return 8'h59;
    endcase
  endfunction

  // Eight PRBS steps; bit 0 newest, octet sent MSB first
  function automatic logic [38:0] prbs_adv(logic [30:0] s, logic [3:0] sel);
    logic [30:0] st;
    logic [7:0]  o;
    logic        b;
    int          ta;
    int          tb;
    st = s;
    o  = '0;
    unique case (sel)
      jstpg_pkg::PAT_PRBS9:  begin ta = 5;  tb = 9;  end
      jstpg_pkg::PAT_PRBS15: begin ta = 14; tb = 15; end
      jstpg_pkg::PAT_PRBS23: begin ta = 18; tb = 23; end
      jstpg_pkg::PAT_PRBS31: begin ta = 28; tb = 31; end
      default:               begin ta = 6;  tb = 7;  end
    endcase
    for (int i = 0; i < 8; i++) begin
      b  = st[ta-1] ^ st[tb-1];
      st = {st[29:0], b};
      o  = {o[6:0], b};
    end
    return {o, st};
  endfunction

  // Per-lane generator and output selection
  for (genvar g = 0; g < NL; g++) begin : g_lane
    localparam logic [7:0] KOCT = 8'(g % GS); // Lane index within group
    logic [30:0] prbs_ff;  // Generator state
    logic [38:0] adv;      // Next octet and state
    logic [7:0]  nxt_oct;  // Next lane octet
    logic        nxt_k;    // Next control flag
    logic        nxt_raw;  // Next bypass flag
    logic        is_prbs;  // PRBS pattern active

    assign is_prbs = (pat >= jstpg_pkg::PAT_PRBS7) && (pat <= jstpg_pkg::PAT_PRBS31);
    assign adv     = prbs_adv(prbs_ff, pat);

    // Distinct nonzero seed per lane gives each its own phase
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        prbs_ff <= 31'(g + 1);
      end else if (is_prbs && lane_on[g]) begin
        prbs_ff <= adv[30:0];
      end
    end

    always_comb begin
      nxt_oct = jstpg_pkg::OCT_ZERO;
      nxt_k   = 1'b0;
      nxt_raw = 1'b0;
      if (!lane_on[g] || state_ff == JSTPG_OFF) begin
        nxt_oct = jstpg_pkg::OCT_ZERO; // Idle while down or disabled
      end else if (is_prbs) begin
        nxt_oct = adv[38:31];
        nxt_raw = 1'b1;
      end else if (pat == jstpg_pkg::PAT_CLOCK) begin
        nxt_oct = clk_half_ff ? jstpg_pkg::OCT_ZERO : jstpg_pkg::OCT_ONES;
        nxt_raw = 1'b1;
      end else if (pat == jstpg_pkg::PAT_D215) begin
        nxt_oct = jstpg_pkg::OCT_D215;
      end else if (pat == jstpg_pkg::PAT_K285 && !enc64) begin
        nxt_oct = jstpg_pkg::OCT_K285;
        nxt_k   = 1'b1;
      end else if (state_ff == JSTPG_CGS) begin
        nxt_oct = jstpg_pkg::OCT_K285;
        nxt_k   = 1'b1;
      end else if (state_ff == JSTPG_ILA) begin
        // Multiframe bounded by start and end characters, count between
        if (ila_cnt_ff[4:0] == 5'h00) begin
          nxt_oct = jstpg_pkg::OCT_K280;
          nxt_k   = 1'b1;
        end else if (ila_cnt_ff[4:0] == jstpg_pkg::MF_LAST) begin
          nxt_oct = jstpg_pkg::OCT_K283;
          nxt_k   = 1'b1;
        end else begin
          nxt_oct = {1'b0, ila_cnt_ff};
        end
      end else if (pat == jstpg_pkg::PAT_RAMP) begin
        nxt_oct = ramp_ff;
      end else if (pat == jstpg_pkg::PAT_SHORT) begin
        nxt_oct = frame_ff ? (jstpg_pkg::OCT_ONES - KOCT) : KOCT;
      end else if (pat == jstpg_pkg::PAT_RPAT && !enc64) begin
        nxt_oct = rpat_oct(rpat_idx_ff);
      end else begin
        // Normal data; also 8b/10b-only patterns on 64b/66b
        nxt_oct = fmt_data[g*8 +: 8];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lnk.lane_data[g*8 +: 8] <= '0;
        lnk.lane_k[g]           <= 1'b0;
        lnk.lane_raw[g]         <= 1'b0;
      end else begin
        lnk.lane_data[g*8 +: 8] <= nxt_oct;
        lnk.lane_k[g]           <= nxt_k;
        lnk.lane_raw[g]         <= nxt_raw;
      end
    end
  end

  // Link state visible to the user side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_state_ff <= JSTPG_OFF;
    end else begin
      link_state_ff <= state_ff;
    end
  end
endmodule // jstpg_device_end

/* verilog/jstpg_host_end.sv */
// Receiver/controller end: control registers, sync request and link monitor
`timescale 1ns/100ps
module jstpg_host_end #(
  parameter int NL        = 8,
  parameter int FLUSH_CYC = jstpg_pkg::FLUSH_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  jstpg_if.host           lnk,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata_ff,
  output logic            cal_converter_off_ff
);
  logic [7:0]  ctrl_ff;      // Control register
  logic [2:0]  status_ff;    // Sticky refused and alignment seen; live trusted
  logic [7:0]  lane0_ff;     // Last lane 0 octet
  logic [15:0] sync_cnt_ff;  // Sync request hold counter
  logic [15:0] flush_cnt_ff; // Pipeline flush wait
  logic        pd_ff;        // Previous power state
  logic        restart;      // Link (re)start event
  logic        pd_now;       // Device powered down

  assign pd_now  = ctrl_ff[1] || ctrl_ff[2];
  assign restart = (wr && addr == jstpg_pkg::REG_CTRL && wdata[0] && !ctrl_ff[0]) ||
                   (pd_ff && !pd_now);

  // Control writes; pattern only with the link off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff                 <= jstpg_pkg::CTRL_RESET;
      lnk.test_pattern_select <= jstpg_pkg::PAT_OFF;
      lnk.link_format_select  <= jstpg_pkg::FMT_RESET;
    end else if (wr) begin
      if (addr == jstpg_pkg::REG_CTRL) begin
        ctrl_ff <= wdata;
      end else if (addr == jstpg_pkg::REG_PAT && !ctrl_ff[0]) begin
        lnk.test_pattern_select <= wdata[3:0];
      end else if (addr == jstpg_pkg::REG_FMT && !ctrl_ff[0]) begin
        lnk.link_format_select <= wdata[3:0];
      end
    end
  end

  // Pins follow the control register one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lnk.link_enable      <= 1'b0;
      lnk.powerdown_input  <= 1'b0;
      lnk.full_powerdown   <= 1'b0;
      lnk.chan_b_powerdown <= 1'b0;
      lnk.fec_select       <= 1'b0;
      cal_converter_off_ff <= 1'b1;
      pd_ff                <= 1'b0;
    end else begin
      lnk.link_enable      <= ctrl_ff[0];
      lnk.powerdown_input  <= ctrl_ff[1];
      lnk.full_powerdown   <= ctrl_ff[2];
      lnk.chan_b_powerdown <= ctrl_ff[3];
      lnk.fec_select       <= ctrl_ff[4];
      cal_converter_off_ff <= ctrl_ff[5];
      pd_ff                <= pd_now;
    end
  end

  // Sync request held low after each link start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_cnt_ff        <= '0;
      lnk.sync_request_n <= 1'b1;
    end else if (restart) begin
      sync_cnt_ff        <= 16'(jstpg_pkg::SYNC_REQ_CYC);
      lnk.sync_request_n <= 1'b0;
    end else if (sync_cnt_ff != '0) begin
      sync_cnt_ff        <= sync_cnt_ff - 16'h0001;
      lnk.sync_request_n <= (sync_cnt_ff == 16'h0001);
    end
  end

  // Samples trusted only after the flush wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flush_cnt_ff <= '0;
    end else if (restart || pd_now) begin
      flush_cnt_ff <= 16'(FLUSH_CYC);
    end else if (flush_cnt_ff != '0) begin
      flush_cnt_ff <= flush_cnt_ff - 16'h0001;
    end
  end

  // Status: sticky bits cleared by writing one; a new event wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
      lane0_ff  <= '0;
    end else begin
      lane0_ff <= lnk.lane_data[7:0];
      status_ff[jstpg_pkg::ST_TRUSTED] <= (flush_cnt_ff == '0) && ctrl_ff[0] && !pd_now;
      if (wr && ctrl_ff[0] && (addr == jstpg_pkg::REG_PAT || addr == jstpg_pkg::REG_FMT)) begin
        status_ff[jstpg_pkg::ST_REFUSED] <= 1'b1;
      end else if (wr && addr == jstpg_pkg::REG_STATUS && wdata[jstpg_pkg::ST_REFUSED]) begin
        status_ff[jstpg_pkg::ST_REFUSED] <= 1'b0;
      end
      if (lnk.lane_k[0] && lnk.lane_data[7:0] == jstpg_pkg::OCT_K280) begin
        status_ff[jstpg_pkg::ST_ILA] <= 1'b1;
      end else if (wr && addr == jstpg_pkg::REG_STATUS && wdata[jstpg_pkg::ST_ILA]) begin
        status_ff[jstpg_pkg::ST_ILA] <= 1'b0;
      end
    end
  end

  // Read data in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (rd) begin
      unique case (addr)
        jstpg_pkg::REG_CTRL:   rdata_ff <= ctrl_ff;
        jstpg_pkg::REG_PAT:    rdata_ff <= {4'h0, lnk.test_pattern_select};
        jstpg_pkg::REG_FMT:    rdata_ff <= {4'h0, lnk.link_format_select};
        jstpg_pkg::REG_STATUS: rdata_ff <= {3'h0, lnk.sync_hdr_code, status_ff};
        jstpg_pkg::REG_LANE0:  rdata_ff <= lane0_ff;
        default:               rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
endmodule // jstpg_host_end

/* testbench/jstpg_asserts.sv */
// Concurrent checks on the link between the transmitter and controller ends
`timescale 1ns/100ps
module jstpg_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        powerdown_input,
  input wire logic        full_powerdown,
  input wire logic        chan_b_powerdown,
  input wire logic        link_enable,
  input wire logic        fec_select,
  input wire logic [3:0]  test_pattern_select,
  input wire logic [3:0]  link_format_select,
  input wire logic        sync_request_n,
  input wire logic [63:0] lane_data,
  input wire logic [7:0]  lane_k,
  input wire logic [7:0]  lane_raw,
  input wire logic [7:0]  lane_drv_en,
  input wire logic [1:0]  sync_hdr_code
);
  // One clock domain
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);
  // Power-down; two cycles for the registered enables
  pd_pin_off_a: assert property (powerdown_input [*2] |-> lane_drv_en == 8'h00)
    else $error("lane driver on under power-down pin");
  full_pd_off_a: assert property (full_powerdown [*2] |-> lane_drv_en == 8'h00)
    else $error("lane driver on under config power-down");
  chan_b_off_a: assert property ((link_format_select[3] && chan_b_powerdown) [*3]
    |-> lane_drv_en[7:4] == 4'h0) else $error("group B lane on");
  // Two lanes per group: upper two dark
  lane_count_a: assert property ((link_format_select[1:0] == 2'h1) [*3]
    |-> (lane_drv_en & 8'hcc) == 8'h00) else $error("extra lane powered");
  crc_mode_a: assert property ((link_format_select[2] && !fec_select) [*3]
    |-> sync_hdr_code == jstpg_pkg::SH_CRC12) else $error("header mode not CRC-12");
  fec_mode_a: assert property ((link_format_select[2] && fec_select) [*3]
    |-> sync_hdr_code == jstpg_pkg::SH_FEC) else $error("header mode not FEC");
  // No control characters in 64b/66b
  no_k_64_a: assert property (link_format_select[2] [*3] |-> lane_k == 8'h00)
    else $error("control character in 64b/66b");
  clk_pat_a: assert property ((link_enable && !powerdown_input && !full_powerdown
    && test_pattern_select == jstpg_pkg::PAT_CLOCK) [*4]
    |-> lane_raw[0] && lane_data[7:0] == ~$past(lane_data[7:0]))
    else $error("clock pattern broken");
  prbs_raw_a: assert property ((link_enable && test_pattern_select inside {[4'h1:4'h5]})
    [*3] |-> lane_raw[0] && !lane_k[0]) else $error("PRBS octet not raw");
  cgs_comma_a: assert property ((link_enable && !sync_request_n && !powerdown_input
    && !full_powerdown && !link_format_select[2]
    && test_pattern_select == jstpg_pkg::PAT_REPILA) [*3]
    |-> lane_data[7:0] == jstpg_pkg::OCT_K285 && lane_k[0]) else $error("no comma in CGS");
  // Main scenarios reached
  pd_seen_c: cover property (powerdown_input [*2] ##1 !powerdown_input);
  fec_seen_c: cover property (sync_hdr_code == jstpg_pkg::SH_FEC);
  cgs_seen_c: cover property (link_enable && !sync_request_n ##1 sync_request_n);
endmodule // jstpg_asserts

/* testbench/jstpg_tb.sv */
// Self-checking bench for both link ends
`timescale 1ns/100ps
module jstpg_tb;
  logic        clk = 1'b0;            // 100 MHz
  logic        rst = 1'b1;            // Held for 3 cycles
  logic [7:0]  addr = 8'h00;          // Register port
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [63:0] fmt_data = 64'h0;      // Random user data
  logic [7:0]  rdata_ff;
  logic        cal_converter_off_ff;
  logic        drv_any_ff;
  logic [3:0]  link_state_ff;
  logic [7:0]  rv;                    // Last read value
  logic [63:0] q[$];                  // Captured lane words
  logic [7:0]  pdv[2] = '{8'h23, 8'h25};
  int          rpat[12] = '{'hbe, 'hd7, 'h23, 'h47, 'h6b, 'h8f, 'hb3, 'h14, 'h5e, 'hfb,
                            'h35, 'h59};
  int          ta[6] = '{0, 6, 5, 14, 18, 28}; // Near tap per PRBS code
  int          tb[6] = '{0, 7, 9, 15, 23, 31}; // Far tap per PRBS code
  int          num_errors = 0;
  int          compares = 0;
  int          seed = 72;
  int          bad;
  int          ph;
  jstpg_if #(.NL(8)) lnk ();
  jstpg_device_end #(.NL(8)) u_jstpg_device_end (.clk(clk), .rst(rst), .lnk(lnk),
    .fmt_data(fmt_data), .link_state_ff(link_state_ff), .drv_any_ff(drv_any_ff));
  // Short flush wait
  jstpg_host_end #(.NL(8), .FLUSH_CYC(8)) u_jstpg_host_end (.clk(clk), .rst(rst),
    .lnk(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .cal_converter_off_ff(cal_converter_off_ff));
  jstpg_asserts u_jstpg_asserts (.clk(clk), .rst(rst), .powerdown_input(lnk.powerdown_input),
    .full_powerdown(lnk.full_powerdown), .chan_b_powerdown(lnk.chan_b_powerdown),
    .link_enable(lnk.link_enable), .fec_select(lnk.fec_select),
    .test_pattern_select(lnk.test_pattern_select), .link_format_select(lnk.link_format_select),
    .sync_request_n(lnk.sync_request_n), .lane_data(lnk.lane_data), .lane_k(lnk.lane_k),
    .lane_raw(lnk.lane_raw), .lane_drv_en(lnk.lane_drv_en), .sync_hdr_code(lnk.sync_hdr_code));
  // Clock
  always #5 clk = ~clk;
  // Random user data
  always @(posedge clk) fmt_data <= {$random(seed), $random(seed)};
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_ff;
  endtask
  // Pattern set with link off, then relink and settle
  task automatic run(input logic [3:0] p, input logic [7:0] c);
    wreg(jstpg_pkg::REG_CTRL, 8'h20);
    wreg(jstpg_pkg::REG_PAT, {4'h0, p});
    wreg(jstpg_pkg::REG_CTRL, c);
    repeat (200) @(posedge clk);
  endtask
  // Capture n settled lane words
  task automatic grab(input int n);
    q.delete();
    repeat (n) begin
      @(posedge clk);
      #1 q.push_back(lnk.lane_data);
    end
  endtask
  // Lane 0 bit n, octet sent MSB first
  function automatic logic bitat(input int n);
    return q[n/8][7-n%8];
  endfunction
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog at about four and a half times the expected run
  initial begin
    #150000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rreg(jstpg_pkg::REG_CTRL, rv);
    chk(rv, jstpg_pkg::CTRL_RESET);
    chk({7'h0, cal_converter_off_ff}, 8'h01);
    rreg(8'h3c, rv);
    chk(rv, 8'h00);
    // Each PRBS mode against its recurrence
    for (int p = 1; p < 6; p++) begin
      run(4'(p), 8'h21);
      grab(20);
      bad = 0;
      for (int n = 31; n < 160; n++)
        if (bitat(n) !== (bitat(n - ta[p]) ^ bitat(n - tb[p]))) bad++;
      chk({7'h0, bad > 0}, 8'h00);
      chk({7'h0, q[0][15:0] === {q[0][7:0], q[0][7:0]}}, 8'h00);
    end
    run(jstpg_pkg::PAT_RAMP, 8'h21);
    grab(8);
    for (int i = 1; i < 8; i++) chk(q[i][7:0], q[i-1][7:0] + 8'h01);
    chk(q[3][31:24], q[3][7:0]);
    run(jstpg_pkg::PAT_SHORT, 8'h21);
    grab(4);
    ph = (q[0][7:0] === 8'hff) ? 1 : 0;
    for (int i = 0; i < 4; i++)
      for (int g = 0; g < 4; g++)
        chk(q[i][g*8+:8], ((i + ph) % 2 == 0) ? 8'(g) : 8'(255 - g));
    run(jstpg_pkg::PAT_RPAT, 8'h21);
    grab(13);
    ph = 0;
    for (int i = 0; i < 12; i++) if (q[0][7:0] === 8'(rpat[i])) ph = i;
    for (int i = 0; i < 13; i++) chk(q[i][7:0], 8'(rpat[(ph + i) % 12]));
    run(jstpg_pkg::PAT_D215, 8'h21);
    grab(2);
    chk(q[1][7:0], jstpg_pkg::OCT_D215);
    run(jstpg_pkg::PAT_K285, 8'h21);
    grab(2);
    chk(q[1][7:0], jstpg_pkg::OCT_K285);
    chk({7'h0, lnk.lane_k[0]}, 8'h01);
    run(jstpg_pkg::PAT_CLOCK, 8'h21);
    grab(2);
    chk(q[0][7:0] ^ q[1][7:0], 8'hff);
    // Alignment run loops, no data phase
    run(jstpg_pkg::PAT_REPILA, 8'h21);
    bad = 0;
    repeat (300) begin
      @(posedge clk);
      #1 if (link_state_ff === 4'h8) bad++;
    end
    chk({7'h0, bad > 0}, 8'h00);
    // Pattern write with link up is refused
    wreg(jstpg_pkg::REG_PAT, 8'h00);
    rreg(jstpg_pkg::REG_STATUS, rv);
    chk({7'h0, rv[0]}, 8'h01);
    rreg(jstpg_pkg::REG_PAT, rv);
    chk(rv, {4'h0, jstpg_pkg::PAT_REPILA});
    wreg(jstpg_pkg::REG_STATUS, 8'h01);
    rreg(jstpg_pkg::REG_STATUS, rv);
    chk({7'h0, rv[0]}, 8'h00);
    // Power-down, then relink
    foreach (pdv[i]) begin
      wreg(jstpg_pkg::REG_CTRL, pdv[i]);
      repeat (4) @(posedge clk);
      #1 chk(lnk.lane_drv_en, 8'h00);
      chk({7'h0, drv_any_ff}, 8'h00);
      wreg(jstpg_pkg::REG_CTRL, 8'h21);
      repeat (3) @(posedge clk);
      #1 chk({7'h0, lnk.sync_request_n}, 8'h00);
    end
    // Dual channel, two lanes a group, group B off
    wreg(jstpg_pkg::REG_CTRL, 8'h20);
    wreg(jstpg_pkg::REG_FMT, 8'h09);
    wreg(jstpg_pkg::REG_CTRL, 8'h29);
    repeat (6) @(posedge clk);
    #1 chk(lnk.lane_drv_en, 8'h03);
    // 64b/66b with CRC-12 then FEC
    wreg(jstpg_pkg::REG_CTRL, 8'h20);
    wreg(jstpg_pkg::REG_FMT, 8'h06);
    run(jstpg_pkg::PAT_K285, 8'h21);
    rv = fmt_data[7:0];
    #1 chk({6'h0, lnk.sync_hdr_code}, 8'h01);
    chk(lnk.lane_k, 8'h00);
    chk(lnk.lane_data[7:0], rv);
    run(jstpg_pkg::PAT_D215, 8'h31);
    #1 chk({6'h0, lnk.sync_hdr_code}, 8'h02);
    chk(lnk.lane_data[7:0], jstpg_pkg::OCT_D215);
    test_done();
  end
endmodule // jstpg_tb
